// *** loop_cal.sv ***
`timescale 1ns/1ps
module loop_cal #(
   parameter int NCH = loop_cal_pkg::NUM_CH
) (
   input  wire logic                    clk_sys_i,
   input  wire logic                    resetn_i,
   input  wire logic                    req_valid_i,
   input  wire logic                    req_write_i,
   input  wire loop_cal_pkg::rtp_req_t  req_i,
   output logic                         resp_valid_o,
   output loop_cal_pkg::rtp_resp_t      resp_o,
   input  wire logic [NCH-1:0]          range_0_20_i,
   input  wire logic [NCH-1:0]          unsigned_fmt_i,
   input  wire logic [NCH-1:0]          ch_enable_i,
   input  wire logic                    sample_valid_i,
   input  wire logic [1:0]              sample_ch_i,
   input  wire logic [15:0]             loop_input_current_i,
   output logic [NCH*16-1:0]            count_o,
   output logic [NCH*8-1:0]             status_o
);
   logic [15:0] offset_reg [NCH];
   logic [15:0] maxcnt_reg [NCH];
   logic [7:0]  avg_reg    [NCH];
   logic [NCH-1:0] fmt_prev_reg;
   logic [15:0] wval;
   logic [1:0]  ch_sel;
   logic        sub_ok;
   logic        is_off;
   logic        is_max;
   logic        is_avg;

   assign wval   = {req_i.data_b2, req_i.data_b1};
   assign ch_sel = 2'(req_i.sub_index - 8'd1);
   assign sub_ok = (req_i.sub_index >= 8'd1) && (req_i.sub_index <= 8'(NCH));
   assign is_off = req_i.index_hi == loop_cal_pkg::IDX_HI && req_i.index_lo == loop_cal_pkg::IDX_LO_OFFSET
                   && req_i.length == loop_cal_pkg::LEN_WORD;
   assign is_max = req_i.index_hi == loop_cal_pkg::IDX_HI && req_i.index_lo == loop_cal_pkg::IDX_LO_MAXCNT
                   && req_i.length == loop_cal_pkg::LEN_WORD;
   assign is_avg = req_i.index_hi == loop_cal_pkg::IDX_HI && req_i.index_lo == loop_cal_pkg::IDX_LO_AVG
                   && req_i.length == loop_cal_pkg::LEN_BYTE;

   function automatic logic off_legal(input logic uf, input logic [15:0] v);
      if (uf)
         off_legal = v <= loop_cal_pkg::OFF_U_MAX;
      else
         off_legal = $signed(v) >= $signed(loop_cal_pkg::OFF_S_MIN)
                     && $signed(v) <= $signed(loop_cal_pkg::OFF_S_MAX);
   endfunction

   function automatic logic max_legal(input logic uf, input logic [15:0] v);
      if (uf)
         max_legal = v >= loop_cal_pkg::MAX_U_MIN;
      else
         max_legal = v >= loop_cal_pkg::MAX_S_MIN && v <= loop_cal_pkg::MAX_S_MAX;
   endfunction

   logic           wr_ok;
   logic           wr_take;
   logic [NCH-1:0] wr_off_en;
   logic [NCH-1:0] wr_max_en;
   logic [NCH-1:0] wr_avg_en;
   logic [NCH-1:0] fmt_flip;
   logic           rd_ok;
   logic [15:0]    rd_val;

   // legality follows the addressed channel's present format
   always_comb begin
      wr_ok = 1'b0;
      if (sub_ok) begin
         if (is_off)
            wr_ok = off_legal(unsigned_fmt_i[ch_sel], wval);
         else if (is_max)
            wr_ok = max_legal(unsigned_fmt_i[ch_sel], wval);
         else if (is_avg)
            wr_ok = req_i.data_b1 >= loop_cal_pkg::AVG_MIN && req_i.data_b1 <= loop_cal_pkg::AVG_MAX;
      end
   end

   assign wr_take  = req_valid_i && req_write_i && wr_ok;
   assign fmt_flip = fmt_prev_reg ^ unsigned_fmt_i;

   // one enable per channel, so a write never spills into a neighbour
   always_comb begin
      wr_off_en = '0;
      wr_max_en = '0;
      wr_avg_en = '0;
      for (int i = 0; i < NCH; i++) begin
         if (wr_take && ch_sel == 2'(i)) begin
            wr_off_en[i] = is_off;
            wr_max_en[i] = is_max;
            wr_avg_en[i] = is_avg;
         end
      end
   end

   // a format change reinterprets the stored words, so defaults come back unless a write to that word lands in the same cycle
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fmt_prev_reg <= '0;
      end else begin
         fmt_prev_reg <= unsigned_fmt_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < NCH; i++) begin
            offset_reg[i] <= loop_cal_pkg::OFFSET_RESET;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (wr_off_en[i]) begin
               offset_reg[i] <= wval;
            end else if (fmt_flip[i]) begin
               offset_reg[i] <= loop_cal_pkg::OFFSET_RESET;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < NCH; i++) begin
            maxcnt_reg[i] <= loop_cal_pkg::MAX_S_RESET;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (wr_max_en[i]) begin
               maxcnt_reg[i] <= wval;
            end else if (fmt_flip[i]) begin
               maxcnt_reg[i] <= unsigned_fmt_i[i] ? loop_cal_pkg::MAX_U_RESET : loop_cal_pkg::MAX_S_RESET;
            end
         end
      end
   end

   // averaging is kept for read-back only; samples are not filtered
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < NCH; i++) begin
            avg_reg[i] <= loop_cal_pkg::AVG_RESET;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (wr_avg_en[i]) begin
               avg_reg[i] <= req_i.data_b1;
            end
         end
      end
   end

   always_comb begin
      rd_ok  = 1'b0;
      rd_val = 16'h0000;
      if (sub_ok) begin
         if (is_off) begin
            rd_ok  = 1'b1;
            rd_val = offset_reg[ch_sel];
         end else if (is_max) begin
            rd_ok  = 1'b1;
            rd_val = maxcnt_reg[ch_sel];
         end else if (is_avg) begin
            rd_ok  = 1'b1;
            rd_val = {8'h00, avg_reg[ch_sel]};
         end
      end
   end

   // one-cycle answer: ok low on bad index, sub-index or value
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         resp_valid_o <= 1'b0;
      end else begin
         resp_valid_o <= req_valid_i;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         resp_o <= '0;
      end else if (req_valid_i) begin
         if (req_write_i) begin
            resp_o.ok    <= wr_ok;
            resp_o.value <= 16'h0000;
         end else begin
            resp_o.ok    <= rd_ok;
            resp_o.value <= rd_val;
         end
      end
   end

   // scaling datapath, pipelined over two cycles
   // ideal count = offset + (raw - low) * full / (high - low); the default endpoints make the
   // ideal slopes 2000/4000 and 1600/3200 counts per mA
   logic [1:0]  c1_reg;
   logic        v1_reg;
   logic [16:0] rel_reg;
   logic [16:0] span_reg;
   logic [16:0] span_lo;
   logic [16:0] raw_ext;
   logic [16:0] rel;

   assign raw_ext = {1'b0, loop_input_current_i};
   always_comb begin
      if (range_0_20_i[sample_ch_i]) begin
         span_lo = 17'h00000;
      end else begin
         span_lo = loop_cal_pkg::RAW_4MA;
      end
   end
   assign rel     = (raw_ext > span_lo) ? raw_ext - span_lo : 17'h00000;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         v1_reg   <= 1'b0;
         c1_reg   <= '0;
         rel_reg  <= '0;
         span_reg <= 17'h00001;
      end else begin
         v1_reg   <= sample_valid_i;
         c1_reg   <= sample_ch_i;
         rel_reg  <= rel;
         span_reg <= loop_cal_pkg::RAW_20MA - span_lo;
      end
   end

   // calibrated endpoints: low end sits at the offset, high end at max count
   logic signed [17:0] lo_pt;
   logic signed [17:0] hi_pt;
   logic signed [17:0] full;
   logic signed [35:0] prod;
   logic signed [35:0] scaled;
   logic signed [18:0] cnt;
   logic               uf1;
   assign uf1    = unsigned_fmt_i[c1_reg];
   always_comb begin
      if (uf1) begin
         lo_pt = 18'($unsigned(offset_reg[c1_reg]));
      end else begin
         lo_pt = 18'($signed(offset_reg[c1_reg]));
      end
   end
   assign hi_pt  = 18'($unsigned(maxcnt_reg[c1_reg]));
   assign full   = hi_pt - lo_pt;
   assign prod   = full * $signed({19'h0, rel_reg});
   assign scaled = prod / $signed({19'h0, span_reg});
   assign cnt    = 19'(scaled) + 19'(lo_pt);

   // saturate into the active format; status bit 0 flags a clamped count
   logic [15:0] sat;
   logic [18:0] sat_ext;
   always_comb begin
      if (uf1) begin
         if (cnt < 0) begin
            sat = 16'h0000;
         end else if (cnt > 19'sh0ffff) begin
            sat = 16'hffff;
         end else begin
            sat = cnt[15:0];
         end
      end else begin
         if (cnt < -19'sh08000) begin
            sat = 16'h8000;
         end else if (cnt > 19'sh07fff) begin
            sat = 16'h7fff;
         end else begin
            sat = cnt[15:0];
         end
      end
   end

   // sign-extend in signed format, else every negative count reads as clamped
   assign sat_ext = uf1 ? {3'b000, sat} : {{3{sat[15]}}, sat};

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         count_o <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (!ch_enable_i[i]) begin
               count_o[i*16 +: 16] <= 16'h0000;
            end else if (v1_reg && c1_reg == 2'(i)) begin
               count_o[i*16 +: 16] <= sat;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         status_o <= '0;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (!ch_enable_i[i]) begin
               status_o[i*8 +: 8] <= 8'h00;
            end else if (v1_reg && c1_reg == 2'(i)) begin
               status_o[i*8 +: 8] <= {7'h00, (cnt[18:0] != sat_ext)};
            end
         end
      end
   end
endmodule

// *** loop_cal_pkg.sv ***
package loop_cal_pkg;
   localparam int          NUM_CH          = 4;
   localparam logic [7:0]  IDX_HI          = 8'h24;
   localparam logic [7:0]  IDX_LO_OFFSET   = 8'h00;
   localparam logic [7:0]  IDX_LO_MAXCNT   = 8'h01;
   localparam logic [7:0]  IDX_LO_AVG      = 8'h02;
   localparam logic [7:0]  LEN_WORD        = 8'h02;
   localparam logic [7:0]  LEN_BYTE        = 8'h01;
   localparam logic [15:0] OFF_S_MIN       = 16'hfd01;
   localparam logic [15:0] OFF_S_MAX       = 16'h02ff;
   localparam logic [15:0] OFF_U_MAX       = 16'h05ff;
   localparam logic [15:0] MAX_S_MIN       = 16'h7a01;
   localparam logic [15:0] MAX_S_MAX       = 16'h7fff;
   localparam logic [15:0] MAX_U_MIN       = 16'hf401;
   localparam logic [15:0] OFFSET_RESET    = 16'h0000;
   localparam logic [15:0] MAX_S_RESET     = 16'h7d00;
   localparam logic [15:0] MAX_U_RESET     = 16'hfa00;
   localparam logic [7:0]  AVG_MIN         = 8'h01;
   localparam logic [7:0]  AVG_MAX         = 8'h50;
   localparam logic [7:0]  AVG_RESET       = 8'h01;
   // raw sample: 16-bit fraction of 20 mA full scale (0xffff ~ 20 mA)
   localparam logic [16:0] RAW_4MA         = 17'h03333;
   localparam logic [16:0] RAW_20MA        = 17'h0ffff;

   typedef struct packed {
      logic [7:0] length;
      logic [7:0] index_lo;
      logic [7:0] index_hi;
      logic [7:0] sub_index;
      logic [7:0] data_b1;
      logic [7:0] data_b2;
   } rtp_req_t;

   typedef struct packed {
      logic        ok;
      logic [15:0] value;
   } rtp_resp_t;
endpackage

// *** loop_cal_assertions.sv ***
`timescale 1ns/1ps
module loop_cal_assertions #(
   parameter int NCH = 4
) (
   input  wire logic                    clk_sys_i,
   input  wire logic                    resetn_i,
   input  wire logic                    req_valid_i,
   input  wire logic                    req_write_i,
   input  wire loop_cal_pkg::rtp_req_t  req_i,
   input  wire logic                    resp_valid_o,
   input  wire loop_cal_pkg::rtp_resp_t resp_o,
   input  wire logic [NCH-1:0]          range_0_20_i,
   input  wire logic [NCH-1:0]          unsigned_fmt_i,
   input  wire logic [NCH-1:0]          ch_enable_i,
   input  wire logic                    sample_valid_i,
   input  wire logic [1:0]              sample_ch_i,
   input  wire logic [15:0]             loop_input_current_i,
   input  wire logic [NCH*16-1:0]       count_o,
   input  wire logic [NCH*8-1:0]        status_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);
   wire logic [15:0] val     = {req_i.data_b2, req_i.data_b1};
   wire logic        bad_sub = (req_i.sub_index == 8'h00) || (req_i.sub_index > 8'h04);
   wire logic        fmt_u   = unsigned_fmt_i[req_i.sub_index[1:0] - 2'h1];
   sequence take_s;
      req_valid_i;
   endsequence
   sequence refuse_s;
      resp_valid_o && !resp_o.ok;
   endsequence
   resp_delay_a: assert property (take_s |=> resp_valid_o)
      else $error("no answer one cycle after request");
   resp_spurious_a: assert property (!req_valid_i |=> !resp_valid_o)
      else $error("answer without request");
   sub_reject_a: assert property (take_s and bad_sub |=> refuse_s)
      else $error("bad channel selector accepted");
   len_reject_a: assert property (take_s and req_i.length != 8'h02 && req_i.index_lo != 8'h02 |=> refuse_s)
      else $error("bad length accepted");
   off_range_a: assert property (take_s and req_write_i && !bad_sub && req_i.index_lo == 8'h00 && !fmt_u
                                 && val > 16'h02ff && val < 16'hfd01 |=> refuse_s)
      else $error("signed offset out of range accepted");
   max_range_a: assert property (take_s and req_write_i && !bad_sub && req_i.index_lo == 8'h01 && !fmt_u
                                 && (val < 16'h7a01 || val > 16'h7fff) |=> refuse_s)
      else $error("signed maximum count out of range accepted");
   uoff_range_a: assert property (take_s and req_write_i && !bad_sub && req_i.index_lo == 8'h00 && fmt_u
                                  && val > 16'h05ff |=> refuse_s)
      else $error("unsigned offset out of range accepted");
   umax_range_a: assert property (take_s and req_write_i && !bad_sub && req_i.index_lo == 8'h01 && fmt_u
                                  && val < 16'hf401 |=> refuse_s)
      else $error("unsigned maximum count out of range accepted");
   write_value_a: assert property (take_s and req_write_i |=> resp_o.value == 16'h0000)
      else $error("write answer carries data");
   dis_zero_a: assert property (!ch_enable_i[0] |=> count_o[15:0] == 16'h0000 && status_o[7:0] == 8'h00)
      else $error("disabled channel not zero");
endmodule

// *** loop_sensor_model.sv ***
`timescale 1ns/1ps
module loop_sensor_model (
   input  wire logic        clk_sys_i,
   input  wire logic        send_i,
   input  wire logic [1:0]  ch_i,
   input  wire logic [15:0] code_i,
   output logic             sample_valid_o,
   output logic [1:0]       sample_ch_o,
   output logic [15:0]      current_o
);
   // between samples the line wanders, so a stale code is never read as fresh
   always_ff @(posedge clk_sys_i) begin
      sample_valid_o <= send_i;
      sample_ch_o    <= ch_i;
      current_o      <= send_i ? code_i : ~code_i;
   end
endmodule

// *** loop_cal_tb.sv ***
`timescale 1ns/1ps
module loop_cal_tb;
   typedef struct packed {
      logic [1:0]  op;
      logic [7:0]  lo;
      logic [7:0]  sub;
      logic [15:0] val;
      logic [16:0] exp;
   } row_t;
   logic                    clk_sys_i      = 1'b0;
   logic                    resetn_i       = 1'b0;
   logic                    req_valid_i    = 1'b0;
   logic                    req_write_i    = 1'b0;
   loop_cal_pkg::rtp_req_t  req_i          = '0;
   logic [3:0]              range_0_20_i   = 4'h8;
   logic [3:0]              unsigned_fmt_i = 4'h4;
   logic [3:0]              ch_enable_i    = 4'hf;
   logic                    send           = 1'b0;
   logic [1:0]              s_ch           = 2'h0;
   logic [15:0]             code           = 16'h0000;
   logic                    sample_valid_i;
   logic [1:0]              sample_ch_i;
   logic [15:0]             loop_input_current_i;
   logic                    resp_valid_o;
   loop_cal_pkg::rtp_resp_t resp_o;
   logic [63:0]             count_o;
   logic [31:0]             status_o;
   int                      n_mismatch     = 0;
   int                      num_checks     = 0;
   // op 0 read, 1 write, 2 sample (sub = channel, val = raw code); indexes 0x02 and 0x03 go out with length 1
   row_t rows[] = '{
      '{2'h1, 8'h00, 8'h02, 16'h0040, 17'h10000}, '{2'h1, 8'h00, 8'h02, 16'h0300, 17'h00000},
      '{2'h0, 8'h00, 8'h02, 16'h0000, 17'h10040}, '{2'h0, 8'h00, 8'h01, 16'h0000, 17'h10000},
      '{2'h1, 8'h00, 8'h02, 16'hfd01, 17'h10000}, '{2'h0, 8'h01, 8'h04, 16'h0000, 17'h17d00},
      '{2'h1, 8'h01, 8'h02, 16'h7a00, 17'h00000}, '{2'h1, 8'h01, 8'h02, 16'h7fff, 17'h10000},
      '{2'h0, 8'h01, 8'h03, 16'h0000, 17'h1fa00}, '{2'h1, 8'h00, 8'h03, 16'h05ff, 17'h10000},
      '{2'h1, 8'h00, 8'h03, 16'h0600, 17'h00000}, '{2'h1, 8'h01, 8'h03, 16'hf400, 17'h00000},
      '{2'h0, 8'h02, 8'h03, 16'h0000, 17'h10001}, '{2'h1, 8'h02, 8'h03, 16'h0051, 17'h00000},
      '{2'h1, 8'h00, 8'h05, 16'h0000, 17'h00000}, '{2'h1, 8'h03, 8'h01, 16'h0000, 17'h00000},
      '{2'h2, 8'h00, 8'h00, 16'hffff, 17'h07d00}, '{2'h2, 8'h00, 8'h00, 16'h3333, 17'h00000},
      '{2'h2, 8'h00, 8'h01, 16'h3333, 17'h0fd01}, '{2'h2, 8'h00, 8'h01, 16'hffff, 17'h07fff},
      '{2'h2, 8'h00, 8'h02, 16'hffff, 17'h0fa00}, '{2'h2, 8'h00, 8'h03, 16'h8000, 17'h03e80}};
   loop_sensor_model sensor (.clk_sys_i(clk_sys_i), .send_i(send), .ch_i(s_ch), .code_i(code),
      .sample_valid_o(sample_valid_i), .sample_ch_o(sample_ch_i), .current_o(loop_input_current_i));
   loop_cal dut (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
      .req_i(req_i), .resp_valid_o(resp_valid_o), .resp_o(resp_o), .range_0_20_i(range_0_20_i),
      .unsigned_fmt_i(unsigned_fmt_i), .ch_enable_i(ch_enable_i), .sample_valid_i(sample_valid_i),
      .sample_ch_i(sample_ch_i), .loop_input_current_i(loop_input_current_i), .count_o(count_o),
      .status_o(status_o));
   task automatic check(input logic [16:0] got, input logic [16:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic run(input row_t r);
      @(posedge clk_sys_i);
      if (r.op[1]) begin
         send <= 1'b1;
         s_ch <= r.sub[1:0];
         code <= r.val;
         @(posedge clk_sys_i);
         send <= 1'b0;
         repeat (4) @(posedge clk_sys_i);
         #1;
         check({1'b0, count_o[16*r.sub[1:0] +: 16]}, r.exp);
         check({9'h000, status_o[8*r.sub[1:0] +: 8]}, 17'h00000);
      end else begin
         req_valid_i <= 1'b1;
         req_write_i <= r.op[0];
         req_i <= '{r.lo[0] && r.lo[1] ? 8'h01 : (r.lo[1] ? 8'h01 : 8'h02), r.lo, 8'h24, r.sub, r.val[7:0], r.val[15:8]};
         @(posedge clk_sys_i);
         req_valid_i <= 1'b0;
         #1;
         check(resp_o, r.exp);
         check({16'h0000, resp_valid_o}, 17'h00001);
      end
   endtask
   always #12.5 clk_sys_i = ~clk_sys_i;
   initial begin
      repeat (4) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      @(posedge clk_sys_i);
      foreach (rows[i]) run(rows[i]);
      run('{2'h2, 8'h00, 8'h00, 16'hffff, 17'h07d00});
      @(posedge clk_sys_i);
      ch_enable_i <= 4'he;
      repeat (2) @(posedge clk_sys_i);
      #1;
      check({1'b0, count_o[15:0]} | {9'h000, status_o[7:0]}, 17'h00000);
      run('{2'h2, 8'h00, 8'h00, 16'hffff, 17'h00000});
      // mid-run reset must drop calibration back to defaults
      @(posedge clk_sys_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      @(posedge clk_sys_i);
      run('{2'h0, 8'h00, 8'h02, 16'h0000, 17'h10000});
      test_done();
   end
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      n_mismatch++;
      test_done();
   end
endmodule
bind loop_cal loop_cal_assertions #(.NCH(NCH)) chk (
   .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
   .req_i(req_i), .resp_valid_o(resp_valid_o), .resp_o(resp_o), .range_0_20_i(range_0_20_i),
   .unsigned_fmt_i(unsigned_fmt_i), .ch_enable_i(ch_enable_i), .sample_valid_i(sample_valid_i),
   .sample_ch_i(sample_ch_i), .loop_input_current_i(loop_input_current_i), .count_o(count_o),
   .status_o(status_o));
